//--- src/bsc_engine.sv
// Checksum engine top with its input byte buffer
// Overview of operation
// R1: 16-bit or 32-bit polynomial, matching result width
// R2: Each written byte is next stream element
// R3: Result reached only via byte pointer, data
// R4: Extra register returns bit-reversed written value
// R5: Byte XORed into result top bits first
// R6: First byte uses all-zero or all-one start
// R7: MSB one: shift left then XOR polynomial
// R8: MSB zero: shift left only
// R9: Eight steps per byte before next accepted
// R10: Control reloads initial value before new stream
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************
// Input buffer
// ***********************************************************
module bsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW:0] wptr_r; // Write pointer with wrap bit
  logic [AW:0] rptr_r; // Read pointer with wrap bit
  logic push; // Byte accepted
  logic pop; // Byte taken
  // Full when pointers differ only in the wrap bit
  assign in_ready = !((wptr_r[AW] != rptr_r[AW]) &&
                      (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
  assign out_valid = (wptr_r != rptr_r);
  assign out_data = mem[rptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Storage write, no reset needed on data
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wptr_r[AW-1:0]] <= in_data;
    end
  end
  // Pointer update
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
    end
    else
    begin
      if (push)
        wptr_r <= wptr_r + 1'b1;
      if (pop)
        rptr_r <= rptr_r + 1'b1;
    end
  end
endmodule : bsc_fifo

// ***********************************************************
// Engine top
// ***********************************************************
module bsc_engine #(
  parameter logic [15:0] POLY16 = bsc_pkg::BSC_POLY16_DEF,
  parameter logic [31:0] POLY32 = bsc_pkg::BSC_POLY32_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Byte stream into the input buffer
  input wire logic stream_valid,
  input wire logic [bsc_pkg::BSC_BYTE_W-1:0] stream_data,
  output logic stream_ready,
  // Configuration levels and reload pulse
  input wire logic mode_wide, // 1: 32-bit, 0: 16-bit
  input wire logic init_ones, // 1: start at all ones
  input wire logic init_req, // Pulse: reload start value
  // Indirect result access
  input wire logic [bsc_pkg::BSC_PTR_W-1:0] result_byte_pointer,
  input wire logic result_wr, // Pulse: load selected byte, ignored while busy
  input wire logic [bsc_pkg::BSC_BYTE_W-1:0] result_wr_data,
  output logic [bsc_pkg::BSC_BYTE_W-1:0] result_data_port,
  // Bit reverse register
  input wire logic rev_wr,
  input wire logic [bsc_pkg::BSC_BYTE_W-1:0] rev_wr_data,
  output logic [bsc_pkg::BSC_BYTE_W-1:0] rev_data,
  // Status
  output logic busy
);
  import bsc_pkg::*;

  bsc_state_type state_r; // Engine state
  logic [3:0] step_r; // Bit steps done in current byte
  logic [BSC_RES_W-1:0] crc_r; // Hidden running result
  logic init_pend_r; // Reload waiting for idle
  logic fifo_valid; // Buffered byte present
  logic [BSC_BYTE_W-1:0] fifo_data; // Oldest buffered byte
  logic pop; // Byte taken this cycle
  logic apply_init; // Reload happens this cycle
  logic apply_wr; // Byte load happens this cycle
  logic [BSC_RES_W-1:0] mask; // Result width mask
  logic [BSC_RES_W-1:0] poly; // Selected polynomial
  logic [BSC_RES_W-1:0] start_val; // Selected start value
  logic [BSC_RES_W-1:0] byte_top; // Byte aligned at top bits
  logic [BSC_RES_W-1:0] step_val; // Result after one bit step
  logic msb; // Top bit of result in current width

  // ***********************************************************
  // Buffer in the data path
  // ***********************************************************
  bsc_fifo #(
    .WIDTH(BSC_BYTE_W),
    .DEPTH(BSC_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(stream_valid),
    .in_data(stream_data),
    .in_ready(stream_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(pop)
  );

  // ***********************************************************
  // Width selection
  // ***********************************************************
  // Narrow mode keeps the upper half at zero
  assign mask = mode_wide ? BSC_MASK32 : BSC_MASK16; // R1
  assign poly = mode_wide ? POLY32 : {16'h0000, POLY16}; // R1
  assign msb = mode_wide ? crc_r[BSC_MSB32] : crc_r[BSC_MSB16];
  assign start_val = init_ones ? mask : BSC_RES_RST; // R6
  // Byte goes to the most significant bits of the result
  assign byte_top = mode_wide ?
    ({24'h00_0000, fifo_data} << BSC_SHIFT32) :
    ({24'h00_0000, fifo_data} << BSC_SHIFT16); // R5
  // One conditional shift-and-XOR step
  assign step_val = msb ? (((crc_r << 1) ^ poly) & mask) // R7
                        : ((crc_r << 1) & mask); // R8

  // ***********************************************************
  // Accept and command decisions
  // ***********************************************************
  // Reload beats a load, a load beats a new byte
  assign apply_init = (state_r == BSC_ST_IDLE) && init_pend_r; // R10
  assign apply_wr = (state_r == BSC_ST_IDLE) && !init_pend_r &&
                    result_wr;
  // A byte is taken only once the previous one is done
  assign pop = (state_r == BSC_ST_IDLE) && !init_pend_r &&
               !result_wr && fifo_valid; // R9
  assign busy = (state_r == BSC_ST_SHIFT) || init_pend_r;

  // ***********************************************************
  // Pending reload flag
  // ***********************************************************
  // A request arriving as the old one is applied is kept
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      init_pend_r <= 1'b0;
    else if (init_req)
      init_pend_r <= 1'b1; // Set wins over clear
    else if (apply_init)
      init_pend_r <= 1'b0;
  end

  // ***********************************************************
  // State and step counter
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= BSC_ST_IDLE;
      step_r <= BSC_STEP_ZERO;
    end
    else
    begin
      unique case (state_r)
        BSC_ST_IDLE:
        begin
          // Start stepping after the byte is folded in
          if (pop)
          begin
            state_r <= BSC_ST_SHIFT;
            step_r <= BSC_STEP_ZERO;
          end
        end
        BSC_ST_SHIFT:
        begin
          // Eight steps, then back for the next byte
          if (step_r == BSC_STEPS - 4'h1)
            state_r <= BSC_ST_IDLE; // R9
          step_r <= step_r + 4'h1;
        end
      endcase
    end
  end

  // ***********************************************************
  // Running result
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      crc_r <= BSC_RES_RST;
    else if (apply_init)
      crc_r <= start_val; // R6
    else if (apply_wr)
    begin
      // Byte load through the pointer, narrow mode drops top half
      crc_r[result_byte_pointer*8 +: 8] <= result_wr_data; // R3
      if (!mode_wide)
        crc_r[31:16] <= 16'h0000;
    end
    else if (pop)
      crc_r <= (crc_r ^ byte_top) & mask; // R2 R5
    else if (state_r == BSC_ST_SHIFT)
      crc_r <= step_val; // R7 R8
  end

  // ***********************************************************
  // Indirect read port and bit reverse
  // ***********************************************************
  // Registered view of the selected byte
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      result_data_port <= BSC_BYTE_RST;
    else
      result_data_port <= crc_r[result_byte_pointer*8 +: 8]; // R3
  end

  // Reversal costs only wiring, no engine time
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rev_data <= BSC_BYTE_RST;
    else if (rev_wr)
      rev_data <= {<<{rev_wr_data}}; // R4
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  logic [3:0] chk_cnt_r; // Cycles since last byte taken
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      chk_cnt_r <= 4'h0;
    else if (pop)
      chk_cnt_r <= 4'h1;
    else if (chk_cnt_r != 4'h0 && chk_cnt_r != 4'hF)
      chk_cnt_r <= chk_cnt_r + 4'h1;
  end

  AST_NARROW_TOP_ZERO: assert property ( // R1
    @(posedge mclk) disable iff (!rst_n)
    (!mode_wide && state_r == BSC_ST_SHIFT) |=> crc_r[31:16] == 16'h0)
    else $error("Narrow result has upper bits set");

  AST_FOLD_TOP: assert property ( // R5
    @(posedge mclk) disable iff (!rst_n)
    (pop && mode_wide) |=>
      crc_r == ($past(crc_r) ^ {$past(fifo_data), 24'h00_0000}))
    else $error("Byte not folded into top bits");

  AST_STEP_POLY: assert property ( // R7
    @(posedge mclk) disable iff (!rst_n)
    (state_r == BSC_ST_SHIFT && mode_wide && crc_r[31]) |=>
      crc_r == (($past(crc_r) << 1) ^ POLY32))
    else $error("Set top bit did not apply polynomial");

  AST_STEP_SHIFT: assert property ( // R8
    @(posedge mclk) disable iff (!rst_n)
    (state_r == BSC_ST_SHIFT && mode_wide && !crc_r[31]) |=>
      crc_r == ($past(crc_r) << 1))
    else $error("Clear top bit did not plain shift");

  AST_EIGHT_STEPS: assert property ( // R9
    @(posedge mclk) disable iff (!rst_n)
    pop |=> (state_r == BSC_ST_SHIFT) [*8] ##1 state_r == BSC_ST_IDLE)
    else $error("Byte not stepped exactly eight times");

  AST_NO_EARLY_POP: assert property ( // R9
    @(posedge mclk) disable iff (!rst_n)
    pop |-> (chk_cnt_r == 4'h0 || chk_cnt_r >= BSC_STEPS + 4'h1))
    else $error("Next byte taken before eight steps");

  AST_INIT_VALUE: assert property ( // R6
    @(posedge mclk) disable iff (!rst_n)
    apply_init |=> crc_r == $past(start_val))
    else $error("Reload did not give start value");

  AST_INIT_SERVED: assert property ( // R10
    @(posedge mclk) disable iff (!rst_n)
    init_req |-> ##[1:10] apply_init)
    else $error("Reload request not served in time");

  AST_READ_PORT: assert property ( // R3
    @(posedge mclk) disable iff (!rst_n)
    ##1 result_data_port ==
      $past(crc_r[result_byte_pointer*8 +: 8]))
    else $error("Data port does not show selected byte");

  AST_REVERSE: assert property ( // R4
    @(posedge mclk) disable iff (!rst_n)
    rev_wr |=> rev_data[0] == $past(rev_wr_data[7]) &&
               rev_data[7] == $past(rev_wr_data[0]))
    else $error("Reverse register wrong");

  COV_WIDE_BYTE: cover property (
    @(posedge mclk) disable iff (!rst_n) pop && mode_wide);
  COV_NARROW_BYTE: cover property (
    @(posedge mclk) disable iff (!rst_n) pop && !mode_wide);
  COV_FIFO_FULL: cover property (
    @(posedge mclk) disable iff (!rst_n) stream_valid && !stream_ready);
  COV_INIT_BUSY: cover property (
    @(posedge mclk) disable iff (!rst_n)
    init_req && state_r == BSC_ST_SHIFT);
endmodule : bsc_engine

`default_nettype wire

//--- src/bsc_pkg.sv
// Package of constants and types for the byte stream checksum unit
`default_nettype none
package bsc_pkg;
  // ***********************************************************
  // Widths
  // ***********************************************************
  localparam int BSC_BYTE_W = 8; // Stream element width
  localparam int BSC_RES_W = 32; // Widest result width
  localparam int BSC_PTR_W = 2; // Byte pointer width
  localparam int BSC_FIFO_DEPTH = 16; // Input buffer depth in bytes
  // ***********************************************************
  // Counts, positions and reset values
  // ***********************************************************
  localparam logic [3:0] BSC_STEPS = 4'h8; // Bit steps per byte
  localparam logic [3:0] BSC_STEP_ZERO = 4'h0; // Step counter reset
  localparam int BSC_MSB32 = 31; // Top bit in wide mode
  localparam int BSC_MSB16 = 15; // Top bit in narrow mode
  localparam int BSC_SHIFT32 = 24; // Byte lands at top of wide result
  localparam int BSC_SHIFT16 = 8; // Byte lands at top of narrow result
  localparam logic [31:0] BSC_MASK32 = 32'hFFFF_FFFF; // Wide mask
  localparam logic [31:0] BSC_MASK16 = 32'h0000_FFFF; // Narrow mask
  localparam logic [31:0] BSC_RES_RST = 32'h0000_0000; // Result at reset
  localparam logic [7:0] BSC_BYTE_RST = 8'h00; // Byte outputs at reset
  // Default generator polynomials, plain values, overridable
  localparam logic [15:0] BSC_POLY16_DEF = 16'h1021;
  localparam logic [31:0] BSC_POLY32_DEF = 32'h04C1_1DB7;
  // ***********************************************************
  // Engine states
  // ***********************************************************
  typedef enum logic [0:0] {
    BSC_ST_IDLE = 1'b0, // Waiting for a byte or a command
    BSC_ST_SHIFT = 1'b1 // Stepping the eight bits of a byte
  } bsc_state_type;
endpackage : bsc_pkg
`default_nettype wire

//--- verification/bsc_engine_test.sv
// Self-checking bench for the byte stream checksum engine
`timescale 1ns/1ps
`default_nettype none
module bsc_engine_test;
  import bsc_pkg::*;
  // ***********************************************************
  // Signals
  // ***********************************************************
  logic mclk, rst_n, stream_valid, stream_ready, mode_wide, init_ones;
  logic init_req, result_wr, rev_wr, busy, saw_full;
  logic [BSC_BYTE_W-1:0] stream_data, result_wr_data, rev_wr_data, b;
  logic [BSC_BYTE_W-1:0] result_data_port, rev_data;
  logic [BSC_PTR_W-1:0] result_byte_pointer;
  logic [31:0] seed, model;
  int mismatches, n_checks, cnt;
  int lens[4] = '{20, 3, 18, 1}; // The 20-byte run overfills the buffer, the 18-byte run just fills it
  bsc_engine uut (
    .mclk(mclk), .rst_n(rst_n),
    .stream_valid(stream_valid), .stream_data(stream_data),
    .stream_ready(stream_ready),
    .mode_wide(mode_wide), .init_ones(init_ones), .init_req(init_req),
    .result_byte_pointer(result_byte_pointer), .result_wr(result_wr),
    .result_wr_data(result_wr_data), .result_data_port(result_data_port),
    .rev_wr(rev_wr), .rev_wr_data(rev_wr_data), .rev_data(rev_data),
    .busy(busy)
  );
  // Free running 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  // ***********************************************************
  // Helpers
  // ***********************************************************
  // Xorshift source, fixed seed so runs repeat
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd8
  // Reference fold of one byte, eight conditional steps
  function automatic logic [31:0] fold(input logic [31:0] r,
    input logic [7:0] d, input logic w);
    logic msb;
    r = r ^ (w ? {d, 24'h00_0000} : {16'h0000, d, 8'h00});
    for (int i = 0; i < 8; i++)
    begin
      msb = w ? r[31] : r[15];
      r = r << 1;
      if (msb) r ^= w ? BSC_POLY32_DEF : {16'h0000, BSC_POLY16_DEF};
    end
    return r & (w ? BSC_MASK32 : BSC_MASK16);
  endfunction : fold
  // Bit order flipped, for the reverse register
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = d[7 - i];
    return r;
  endfunction : rev8
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask : check
  // Offer a byte and hold it until the buffer takes it
  task automatic push(input logic [7:0] d);
    int n;
    n = 0;
    stream_valid = 1'b1;
    stream_data = d;
    while (stream_ready !== 1'b1 && n < 500)
    begin
      saw_full = 1'b1;
      @(negedge mclk);
      n++;
    end
    if (n >= 500)
      check(32'h0000_0000, 32'h0000_0001, "byte never taken");
    @(negedge mclk);
  endtask : push
  // Busy may dip for one cycle between bytes, so ask for three
  task automatic idle_wait();
    int n, q;
    n = 0;
    q = 0;
    while (q < 3 && n < 3000)
    begin
      @(negedge mclk);
      q = (busy === 1'b0) ? q + 1 : 0;
      n++;
    end
    if (q < 3)
      check(32'h0000_0000, 32'h0000_0001, "engine never idle");
  endtask : idle_wait
  // Walk the pointer over all four result bytes
  task automatic read_all();
    for (int p = 0; p < 4; p++)
    begin
      result_byte_pointer = p[1:0];
      @(negedge mclk);
      check({24'h00_0000, result_data_port}, {24'h00_0000, model[p*8+:8]},
        "result byte");
    end
  endtask : read_all
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  // Watchdog, far beyond the several hundred cycles the tests need
  initial
  begin
    #600_000;
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial
  begin
    seed = 32'hd377_b96d;
    {rst_n, stream_valid, mode_wide, init_ones, init_req} = 5'b0_0000;
    {result_wr, rev_wr, saw_full} = 3'b000;
    {stream_data, result_wr_data, rev_wr_data} = 24'h00_0000;
    result_byte_pointer = 2'b00;
    repeat (20) @(negedge mclk);
    check({busy, stream_ready}, 32'h0000_0001, "reset status");
    check({rev_data, result_data_port}, 32'h0000_0000, "reset bytes");
    rst_n = 1'b1;
    @(negedge mclk);
    $display("test reset done");
    // Reverse register, corners then random values
    rev_wr = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      b = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : rnd8();
      rev_wr_data = b;
      @(negedge mclk);
      check({24'h00_0000, rev_data}, {24'h00_0000, rev8(b)}, "rev");
    end
    rev_wr = 1'b0;
    rev_wr_data = 8'h5A;
    repeat (3) @(negedge mclk);
    check({24'h00_0000, rev_data}, {24'h00_0000, rev8(b)}, "rev hold");
    $display("test reverse done");
    // Streams in every width and start value, reload between them
    for (int c = 0; c < 4; c++)
    begin
      mode_wide = c[0];
      init_ones = c[1];
      init_req = 1'b1;
      @(negedge mclk);
      init_req = 1'b0;
      idle_wait();
      model = c[1] ? (c[0] ? BSC_MASK32 : BSC_MASK16) : BSC_RES_RST;
      read_all();
      for (int k = 0; k < lens[c]; k++)
      begin
        b = rnd8();
        push(b);
        model = fold(model, b, c[0]);
      end
      stream_valid = 1'b0;
      idle_wait();
      read_all();
      $display("test stream %0d done", c);
    end
    check({31'h0, saw_full}, 32'h0000_0001, "buffer refused");
    // Load the result by bytes, then fold one byte from it
    for (int w = 0; w < 2; w++)
    begin
      mode_wide = w[0];
      result_wr = 1'b1;
      for (int p = 0; p < 4; p++)
      begin
        result_byte_pointer = p[1:0];
        result_wr_data = rnd8();
        model[p*8+:8] = result_wr_data;
        @(negedge mclk);
      end
      result_wr = 1'b0;
      model = model & (w[0] ? BSC_MASK32 : BSC_MASK16);
      read_all();
      b = rnd8();
      push(b);
      stream_valid = 1'b0;
      cnt = 0;
      repeat (20)
      begin
        @(negedge mclk);
        cnt += (busy === 1'b1) ? 1 : 0;
      end
      check(cnt, 32'h0000_0008, "steps per byte");
      model = fold(model, b, w[0]);
      read_all();
      $display("test seeded fold %0d done", w);
    end
    // Reload asked mid-byte waits for the steps, then sets the start
    push(8'hA5);
    stream_valid = 1'b0;
    @(negedge mclk);
    init_req = 1'b1;
    @(negedge mclk);
    init_req = 1'b0;
    check({31'h0, busy}, 32'h0000_0001, "reload waits");
    idle_wait();
    model = BSC_MASK32;
    read_all();
    $display("test busy reload done");
    close_out();
  end
endmodule : bsc_engine_test
`default_nettype wire
